// [hdl/reset_sequencer_defs.svh]
/*
 * Timing counts, reset values and options for the reset sequencer.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef RESET_SEQUENCER_DEFS_SVH
`define RESET_SEQUENCER_DEFS_SVH

`define OSC_PER_MCYCLE      12
`define SAMPLE_STATE        5
`define SAMPLE_PHASE        2
`define QUALIFY_MCYCLES     2
`define OSC_SETTLE_PERIODS  1536
`define PORT_RESET_VALUE    8'hff
`define STACK_RESET_VALUE   8'h07
`define POR_OPTION_ON       1'b1

`endif

// [hdl/reset_sequencer_pkg.sv]
/*
 * Types shared by the reset sequencer files.
 * Assumes the defs header is on the include path.
 */
`include "reset_sequencer_defs.svh"

package reset_sequencer_pkg;

	// Phase of the machine cycle: state 1..6, phase 0..1.
	typedef struct packed {
		logic [2:0] state;
		logic       phase;
	} mcycle_pos_t;

	// Reset-state outputs that go to the core and pins together.
	typedef struct packed {
		logic       core_reset;
		logic       port_force;
		logic       ale;
		logic       program_store_strobe_n;
		logic       cpu_clk_en;
	} reset_out_t;

	typedef enum logic [1:0] {
		PWR_WAIT,
		PWR_SETTLE,
		PWR_RUN
	} pwr_state_t;

endpackage : reset_sequencer_pkg

// [hdl/mcycle_timer.sv]
/*
 * Machine cycle timer: divides the oscillator clock into 12-period
 * machine cycles and marks the state 5, phase 2 sampling slot.
 * Assumes clk is the oscillator clock.
 */
`timescale 1ns/1ns
`include "reset_sequencer_defs.svh"

module mcycle_timer #(
	parameter int OSC_PER_MCYCLE = `OSC_PER_MCYCLE
) (
	input  wire logic                              clk,
	input  wire logic                              srst,
	output reset_sequencer_pkg::mcycle_pos_t       pos,
	output logic                                   sample_slot
);

	logic [3:0] osc_cnt_r;
	logic [3:0] osc_cnt_nxt;

	// Counts oscillator periods 0..11 of the current machine cycle.
	always_comb begin
		if (osc_cnt_r == 4'(OSC_PER_MCYCLE - 1)) begin
			osc_cnt_nxt = 4'h0;
		end else begin
			osc_cnt_nxt = osc_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			osc_cnt_r <= 4'h0;
		end else begin
			osc_cnt_r <= osc_cnt_nxt;
		end
	end

	// Two periods per state; states are numbered from one.
	assign pos.state   = 3'(osc_cnt_r[3:1] + 3'h1);
	assign pos.phase   = osc_cnt_r[0];
	assign sample_slot = (osc_cnt_r == 4'((`SAMPLE_STATE - 1) * 2 + (`SAMPLE_PHASE - 1)));

	cnt_wrap_a: assert property (@(posedge clk) disable iff (srst)
		osc_cnt_r == 4'(OSC_PER_MCYCLE - 1) |=> osc_cnt_r == 4'h0)
		else $error("Machine cycle counter did not wrap at twelve.");

endmodule : mcycle_timer

// [hdl/reset_sequencer.sv]
/*
 * Reset sequencer of an 8-bit microcontroller: pin sampling and
 * qualification, power-on settle gating, port and strobe reset levels.
 * Assumes clk is the oscillator clock and srst the simulation reset;
 * the power-on detector delivers a synchronous supply-valid level.
 */
// What this block does
// - pin or power-on detector both reset
// - sample pin at state five phase two
// - reset after two high machine cycle samples
// - repeat internal reset while pin high
// - ports forced immediately when pin rises
// - address latch and store strobes high
// - internal RAM untouched by reset
// - port reset levels are parameters, default ones
// - invalid supply drives ports to reset levels
// - gate CPU clock 1536 periods after power-on
// - option removes the power-on detector
`timescale 1ns/1ns
`include "reset_sequencer_defs.svh"

module reset_sequencer #(
	parameter logic [7:0] PORT0_RESET  = `PORT_RESET_VALUE,
	parameter logic [7:0] PORT1_RESET  = `PORT_RESET_VALUE,
	parameter logic [7:0] PORT2_RESET  = `PORT_RESET_VALUE,
	parameter logic [7:0] PORT3_RESET  = `PORT_RESET_VALUE,
	parameter logic       POR_ENABLE   = `POR_OPTION_ON,
	parameter int         SETTLE_COUNT = `OSC_SETTLE_PERIODS
) (
	input  wire logic                           clk,
	input  wire logic                           srst,
	input  wire logic                           reset_pin,
	input  wire logic                           supply_valid,
	output reset_sequencer_pkg::reset_out_t     rst_out,
	output logic [31:0]                         port_reset_levels,
	output logic [7:0]                          stack_reset_value,
	output logic                                ram_write_block
);

	reset_sequencer_pkg::mcycle_pos_t pos;
	logic                             sample_slot;

	// The timer marks the single slot per machine cycle in which the pin is looked at.
	mcycle_timer #(
		.OSC_PER_MCYCLE(`OSC_PER_MCYCLE)
	) u_timer (
		.clk        (clk),
		.srst       (srst),
		.pos        (pos),
		.sample_slot(sample_slot)
	);

	// Pin sampling and qualification state.
	logic       pin_meta_r,   pin_sync_r;
	logic [1:0] high_cnt_r,   high_cnt_nxt;
	logic       pin_rst_r,    pin_rst_nxt;

	// Two flops bring the asynchronous pin in; the first one feeds only the second.
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
		end else begin
			pin_meta_r <= reset_pin;
			pin_sync_r <= pin_meta_r;
		end
	end

	// One sample per machine cycle; two high samples in a row qualify the reset.
	always_comb begin
		high_cnt_nxt = high_cnt_r;
		pin_rst_nxt  = pin_rst_r;
		if (sample_slot) begin
			if (pin_sync_r) begin
				if (high_cnt_r != 2'(`QUALIFY_MCYCLES)) begin
					high_cnt_nxt = high_cnt_r + 2'h1;
				end
				// Reapplied every machine cycle while the pin stays high.
				pin_rst_nxt = (high_cnt_r + 2'h1 >= 2'(`QUALIFY_MCYCLES));
			end else begin
				high_cnt_nxt = 2'h0;
				pin_rst_nxt  = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			high_cnt_r <= 2'h0;
			pin_rst_r  <= 1'b0;
		end else begin
			high_cnt_r <= high_cnt_nxt;
			pin_rst_r  <= pin_rst_nxt;
		end
	end

	// Power-on settle sequencing.
	reset_sequencer_pkg::pwr_state_t pwr_r, pwr_nxt;
	logic [11:0]                     settle_r, settle_nxt;
	logic                            por_active;

	// Without the detector option the supply is treated as always valid.
	assign por_active = POR_ENABLE & ~supply_valid;

	// Clocks stay gated from the core for SETTLE_COUNT periods after supply turns valid.
	always_comb begin
		pwr_nxt    = pwr_r;
		settle_nxt = settle_r;
		case (pwr_r)
			reset_sequencer_pkg::PWR_WAIT: begin
				settle_nxt = 12'h0;
				if (!POR_ENABLE || supply_valid) begin
					pwr_nxt = reset_sequencer_pkg::PWR_SETTLE;
				end
			end
			reset_sequencer_pkg::PWR_SETTLE: begin
				settle_nxt = settle_r + 12'h1;
				if (settle_r == 12'(SETTLE_COUNT - 1)) begin
					pwr_nxt = reset_sequencer_pkg::PWR_RUN;
				end
			end
			reset_sequencer_pkg::PWR_RUN: begin
				settle_nxt = settle_r;
			end
			default: begin
				pwr_nxt = reset_sequencer_pkg::PWR_WAIT;
			end
		endcase
		if (por_active) begin
			pwr_nxt = reset_sequencer_pkg::PWR_WAIT;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pwr_r    <= reset_sequencer_pkg::PWR_WAIT;
			settle_r <= 12'h0;
		end else begin
			pwr_r    <= pwr_nxt;
			settle_r <= settle_nxt;
		end
	end

	// Output group.
	logic core_rst;
	assign core_rst = pin_rst_r | (pwr_r != reset_sequencer_pkg::PWR_RUN);

	// Ports follow the raw pin at once so pins are safe before qualification.
	assign rst_out.port_force             = reset_pin | core_rst | por_active;
	assign rst_out.core_reset             = core_rst;
	assign rst_out.ale                    = core_rst;
	assign rst_out.program_store_strobe_n = core_rst;
	assign rst_out.cpu_clk_en             = (pwr_r == reset_sequencer_pkg::PWR_RUN);
	assign port_reset_levels              = {PORT3_RESET, PORT2_RESET, PORT1_RESET, PORT0_RESET};
	assign stack_reset_value              = `STACK_RESET_VALUE;
	// RAM is never cleared; only writes are blocked while reset stands.
	assign ram_write_block                = core_rst;

	// Assertions.
	// Two high samples exactly one machine cycle apart make a qualified pin reset.
	sequence two_high_samples_s;
		(sample_slot && pin_sync_r) ##12 (sample_slot && pin_sync_r);
	endsequence

	qualify_two_a: assert property (@(posedge clk) disable iff (srst)
		two_high_samples_s |=> pin_rst_r)
		else $error("Reset not applied after two high samples.");

	low_release_a: assert property (@(posedge clk) disable iff (srst)
		(sample_slot && !pin_sync_r) |=> !pin_rst_r)
		else $error("Pin reset held after a low sample.");

	sample_slot_a: assert property (@(posedge clk) disable iff (srst)
		!sample_slot |=> $stable(pin_rst_r))
		else $error("Pin reset changed outside the sampling slot.");

	ports_now_a: assert property (@(posedge clk) disable iff (srst)
		reset_pin |-> rst_out.port_force)
		else $error("Ports not forced while pin is high.");

	strobes_high_a: assert property (@(posedge clk) disable iff (srst)
		rst_out.core_reset |-> (rst_out.ale && rst_out.program_store_strobe_n))
		else $error("Strobes not high during reset.");

	settle_gate_a: assert property (@(posedge clk) disable iff (srst)
		(pwr_r == reset_sequencer_pkg::PWR_SETTLE && settle_r == 12'h0) |-> !rst_out.cpu_clk_en [*8])
		else $error("CPU clock released too early.");

	settle_len_a: assert property (@(posedge clk) disable iff (srst)
		$rose(rst_out.cpu_clk_en) |-> settle_r == 12'(SETTLE_COUNT))
		else $error("Settle period has the wrong length.");

	por_reset_a: assert property (@(posedge clk) disable iff (srst)
		por_active |=> rst_out.core_reset && !rst_out.cpu_clk_en)
		else $error("Power-on detector did not reset the core.");

	por_ports_a: assert property (@(posedge clk) disable iff (srst)
		por_active |-> rst_out.port_force)
		else $error("Ports not forced while supply is low.");

	por_off_a: assert property (@(posedge clk) disable iff (srst)
		!POR_ENABLE |-> !por_active)
		else $error("Detector active although the option is off.");

	ram_kept_a: assert property (@(posedge clk) disable iff (srst)
		rst_out.core_reset |-> ram_write_block)
		else $error("RAM writable during reset.");

	sample_pos_a: assert property (@(posedge clk) disable iff (srst)
		sample_slot |-> (pos.state == 3'(`SAMPLE_STATE) && pos.phase == 1'(`SAMPLE_PHASE - 1)))
		else $error("Sampling slot is not state five, phase two.");

	reapply_hold_a: assert property (@(posedge clk) disable iff (srst)
		(pin_rst_r && sample_slot && pin_sync_r) |=> pin_rst_r)
		else $error("Internal reset not reapplied while the pin stays high.");

	por_bypass_a: assert property (@(posedge clk) disable iff (srst)
		(!POR_ENABLE && pwr_r == reset_sequencer_pkg::PWR_WAIT) |=> pwr_r == reset_sequencer_pkg::PWR_SETTLE)
		else $error("Settle did not start with the detector option off.");

endmodule : reset_sequencer

// [dv/reset_pin_driver.sv]
/*
 * Far-side model: an external reset circuit that holds the reset pin high for a commanded count of clocks.
 * Assumes the bench pulses go for one falling edge with hold_cycles valid beside it.
 */
`timescale 1ns/1ns

module reset_pin_driver (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [7:0] hold_cycles,
	output logic            reset_pin
);
	logic [7:0] left_r = 8'h00;

	// The pin changes only at falling edges, so the sequencer never sees it move on its sampling edge.
	always @(negedge clk) begin
		if (go) begin
			left_r <= hold_cycles;
		end else if (left_r != 8'h00) begin
			left_r <= left_r - 8'h01;
		end
	end

	// Released pin is driven low as soon as the count reaches zero, never a stale value.
	assign reset_pin = (left_r != 8'h00);
endmodule : reset_pin_driver

// [dv/reset_sequencer_tb_top.sv]
/*
 * Self-checking bench for the reset sequencer, with a second instance built without the power-on detector.
 * Assumes a 100 MHz clock and a short settle count so the run stays brief.
 */
`timescale 1ns/1ns

module reset_sequencer_tb_top;
	localparam int SETTLE = 16;
	logic                               clk = 1'b0;
	logic                               srst = 1'b1;
	logic                               supply_valid = 1'b1;
	logic                               go = 1'b0;
	logic [7:0]                         hold = 8'h00;
	logic                               reset_pin;
	reset_sequencer_pkg::reset_out_t    ro;
	reset_sequencer_pkg::reset_out_t    ro_nopor;
	logic [31:0]                        levels;
	logic [31:0]                        levels_nopor;
	logic [7:0]                         stack;
	logic                               ram_blk;
	int                                 n_errors = 0;
	int                                 compares = 0;
	// Ordinary pulses: pin high time in clocks, and whether a core reset must follow.
	// One machine cycle of high pin never qualifies; two full machine cycles always do.
	logic [7:0]                         row_len [4] = '{8'h05, 8'h0c, 8'h18, 8'h3c};
	logic                               row_exp [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

	// The 10 ns oscillator clock.
	initial begin
		forever #5 clk = ~clk;
	end

	reset_pin_driver reset_pin_driver_inst (.clk(clk), .go(go), .hold_cycles(hold), .reset_pin(reset_pin));

	reset_sequencer #(.SETTLE_COUNT(SETTLE)) reset_sequencer_inst (.clk(clk), .srst(srst), .reset_pin(reset_pin),
		.supply_valid(supply_valid), .rst_out(ro), .port_reset_levels(levels), .stack_reset_value(stack),
		.ram_write_block(ram_blk));

	// Detector masked out: the supply input is held invalid to show it is ignored; one port has its own level.
	reset_sequencer #(.POR_ENABLE(1'b0), .PORT2_RESET(8'h5a), .SETTLE_COUNT(SETTLE))
		reset_sequencer_nopor_inst (.clk(clk), .srst(srst), .reset_pin(reset_pin), .supply_valid(1'b0),
		.rst_out(ro_nopor), .port_reset_levels(levels_nopor), .stack_reset_value(), .ram_write_block());

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	// Counts edges until the CPU clock is let through; the count must lie between the settle time and two more.
	task automatic wait_run;
		int n;
		n = 0;
		while (ro.cpu_clk_en !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 60) begin
				n_errors++;
				end_of_test();
			end
		end
		chk(32'(n >= SETTLE && n <= SETTLE + 2), 32'h1);
	endtask : wait_run

	// One pin pulse; ports must follow the raw pin at once and the core reset only a qualified one.
	task automatic pulse(input logic [7:0] len, input logic exp);
		logic seen;
		seen = 1'b0;
		@(negedge clk);
		go <= 1'b1;
		hold <= len;
		@(negedge clk);
		go <= 1'b0;
		#1 chk(ro.port_force, 1'b1);
		for (int i = 0; i < len + 40; i++) begin
			@(posedge clk);
			#1;
			if (ro.core_reset === 1'b1) seen = 1'b1;
			if (seen && reset_pin) chk(ro.core_reset, 1'b1);
			if (ro.core_reset !== 1'b0) chk({ro.ale, ro.program_store_strobe_n}, 2'h3);
			if (ro.core_reset !== 1'b0) chk(ram_blk, 1'b1);
		end
		chk(seen, exp);
		chk(ro.core_reset, 1'b0);
	endtask : pulse

	// Main sequence: reset release and settle, table of pin pulses, then a supply dip.
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		srst <= 1'b0;
		wait_run();
		chk(ro_nopor.cpu_clk_en, 1'b1);
		chk(levels, 32'hffffffff);
		chk(levels_nopor, 32'hff5affff);
		chk(stack, 8'h07);
		for (int r = 0; r < 4; r++) begin
			pulse(row_len[r], row_exp[r]);
		end
		// A mid-run reset puts every output at its reset level and restarts the settle count.
		@(negedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(ro, 32'h1e);
		@(negedge clk);
		srst <= 1'b0;
		wait_run();
		@(negedge clk);
		supply_valid <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({ro.core_reset, ro.port_force, ro.cpu_clk_en}, 3'h6);
		chk({ro_nopor.core_reset, ro_nopor.port_force, ro_nopor.cpu_clk_en}, 3'h1);
		@(negedge clk);
		supply_valid <= 1'b1;
		wait_run();
		chk(ro.core_reset, 1'b0);
		end_of_test();
	end
endmodule : reset_sequencer_tb_top
